//--- hw/diag_port_defs.vh
// constants for the packet serial diagnostic port
`ifndef DIAG_PORT_DEFS_VH
`define DIAG_PORT_DEFS_VH
// ---------------------------------------------------------------
// apb register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_INT_STAT  12'h008
`define OFS_INT_MASK  12'h00C
`define OFS_PRESET    12'h010
`define OFS_ERR       12'h014
`define OFS_NODE      12'h018
// ---------------------------------------------------------------
// control register fields and reset values
// ---------------------------------------------------------------
`define CTRL_IN_LSB   0
`define CTRL_OUT_LSB  2
`define CTRL_VALID    4
`define RST_PORT      2'h0
`define RST_PRESET    16'h0000
// ---------------------------------------------------------------
// interrupt status bits
// ---------------------------------------------------------------
`define INT_TOKEN     0
`define INT_CAPTURE   1
`define INT_ERROR     2
`define INT_W         3
// ---------------------------------------------------------------
// serial framing and token codes
// ---------------------------------------------------------------
`define TOK_W         4
`define DATA_W        32
`define LINE_W        5
`define TOK_NOP       4'h0
`define TOK_CAP_IR    4'h1
`define TOK_CAP_DR    4'h2
`define TOK_SH_IR     4'h3
`define TOK_SH_DR     4'h4
`define TOK_UPD_IR    4'h5
`define TOK_UPD_DR    4'h6
`define TOK_ROUTE_HI  2'h3
// ---------------------------------------------------------------
// data register selects held in the instruction register
// ---------------------------------------------------------------
`define DR_PRESET     3'h0
`define DR_RESET      3'h1
`define DR_ERR        3'h2
`define DR_BOOT       3'h3
`define DR_NODE       3'h4
`define DR_IC_DATA    3'h5
`define DR_IC_ADDR    3'h6
`define IC_AW         12
`define ERR_W         7
`endif

//--- hw/pin_sync.v
// two flip-flop synchroniser for the four serial inputs
module pin_sync (
  input  wire       core_clk,  // system clock
  input  wire       reset,     // synchronous, active high
  input  wire [3:0] pin_in,    // raw serial inputs
  output reg  [3:0] pin_out    // synchronised copy
);
  reg [3:0] meta_reg;          // first stage, read only by second

  // ---------------------------------------------------------------
  // two stages, constants under reset
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      meta_reg <= 4'h0;
      pin_out  <= 4'h0;
    end else begin
      meta_reg <= pin_in;
      pin_out  <= meta_reg;
    end
  end
endmodule

//--- hw/capture_countdown.v
// capture countdown timer that aligns captures across the chain
module capture_countdown (
  input  wire        core_clk,  // system clock
  input  wire        reset,     // synchronous, active high
  input  wire        start,     // capture token seen
  input  wire [15:0] preset,    // transit delay compensation
  output reg         busy,      // counting down
  output reg         fire       // one-cycle capture pulse
);
  reg [15:0] cnt_reg;           // remaining cycles

  // ---------------------------------------------------------------
  // load on start, fire in the cycle after the count sits at zero
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      cnt_reg <= 16'h0000;
      busy    <= 1'b0;
      fire    <= 1'b0;
    end else begin
      fire <= 1'b0;
      if (start) begin
        cnt_reg <= preset;
        busy    <= 1'b1;
      end else if (busy) begin
        if (cnt_reg == 16'h0000) begin
          fire <= 1'b1;
          busy <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end
endmodule

//--- hw/serial_diag_port.v
// per-node packet serial diagnostic port with apb access
//
// The register addresses and the APB register port were chosen for this implementation.
`include "diag_port_defs.vh"

//-----------------------------------------------------------------
// Operation
// - four serial ports, router, token handler
// - each direction: one input, one output wire
// - normally two ports form the scan path
// - traffic only between neighbours, shared clock
// - 4-bit token, 32 data bits when shifting
// - decode route, capture, shift, update tokens
// - packets pass node to node along chain
// - host sets route, changed only on fault
// - host presets a decrementing capture counter
// - capture token starts count, capture at zero
// - one-bit register resets this node selectively
// - host sets network size and node address
// - reset enters boot level 0, caches locked
// - host loads icache bootstrap, then releases
// - error flags scanned repeatedly by host
// - sticky error bit per data input port
//-----------------------------------------------------------------
module serial_diag_port (
  input  wire        core_clk,       // 100 MHz system clock
  input  wire        reset,          // synchronous, active high
  input  wire [11:0] paddr,          // apb address
  input  wire        psel,           // apb select
  input  wire        penable,        // apb access phase
  input  wire        pwrite,         // apb direction
  input  wire [31:0] pwdata,         // apb write data
  output reg  [31:0] prdata,         // apb read data
  output reg         pready,         // apb ready
  output reg         pslverr,        // apb error, unmapped
  input  wire [3:0]  ser_in,         // serial inputs n,e,s,w
  output reg  [3:0]  ser_out,        // serial outputs n,e,s,w
  input  wire        mem_par_err,    // memory parity error event
  input  wire        msg_par_err,    // message parity error event
  input  wire        addr_rng_err,   // out of range address event
  input  wire [3:0]  link_err,       // data router input port errors
  output reg         node_reset,     // selective node reset
  output reg         cache_lock,     // caches act as memory
  output reg         cpu_release,    // start bootstrap program
  output reg         ic_we,          // icache write strobe
  output reg  [11:0] ic_addr,        // icache word address
  output reg  [31:0] ic_wdata,       // icache write data
  output reg         irq             // level interrupt
);
  // ---------------------------------------------------------------
  // receive state machine, one-hot
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h1;   // waiting for start bit
  localparam [2:0] ST_TOK  = 3'h2;   // collecting token bits
  localparam [2:0] ST_DATA = 3'h4;   // shifting 32 data bits

  wire [3:0]  rx_sync;               // synchronised inputs
  wire        cd_busy;               // countdown active
  wire        cd_fire;               // capture moment
  reg  [2:0]  st_reg;                // receive state
  reg  [5:0]  bit_reg;               // bit counter in packet
  reg  [3:0]  tok_reg;               // token being assembled
  reg  [3:0]  tok_next;              // token with current bit
  reg         sh_dr_reg;             // data phase targets dr
  reg  [4:0]  line_reg;              // forwarding delay line
  reg  [31:0] ir_sr_reg;             // instruction shift register
  reg  [31:0] dr_sr_reg;             // data shift register
  reg  [2:0]  ir_reg;                // selects data register
  reg  [1:0]  in_port_reg;           // upstream port
  reg  [1:0]  out_port_reg;          // downstream port
  reg         route_ok_reg;          // route established
  reg  [15:0] preset_reg;            // countdown preset
  reg  [15:0] node_addr_reg;         // this node's address
  reg  [15:0] net_size_reg;          // network size
  reg  [6:0]  err_reg;               // sticky error flags
  reg  [2:0]  int_stat_reg;          // sticky interrupt events
  reg  [2:0]  int_mask_reg;          // interrupt enables
  reg         boot_lvl_reg;          // 0 = bootstrap level 0
  reg         rx;                    // bit on the active input
  reg  [1:0]  first_port;            // lowest port showing start
  reg  [31:0] rd_mux;                // apb read value
  reg  [31:0] cap_val;               // value of selected dr
  reg         map_hit;               // apb address decoded
  reg         tok_done;              // last token bit this cycle
  reg         route_tok;             // route token completes
  wire        apb_setup;             // setup phase of apb
  wire        apb_wr;                // write taken this edge
  wire [6:0]  err_evt;               // error events this cycle

  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;
  assign err_evt   = {link_err, addr_rng_err, msg_par_err,
                      mem_par_err};

  // ---------------------------------------------------------------
  // pin synchroniser and capture timer
  // ---------------------------------------------------------------
  pin_sync u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (ser_in),
    .pin_out  (rx_sync)
  );

  capture_countdown u_cd (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (tok_done && tok_next == `TOK_CAP_DR),
    .preset   (preset_reg),
    .busy     (cd_busy),
    .fire     (cd_fire)
  );

  // ---------------------------------------------------------------
  // input select and token decode
  // ---------------------------------------------------------------
  // before the route is set, any port may carry the probe packet
  always @* begin
    first_port = 2'h0;
    if (rx_sync[3])
      first_port = 2'h3;
    if (rx_sync[2])
      first_port = 2'h2;
    if (rx_sync[1])
      first_port = 2'h1;
    if (rx_sync[0])
      first_port = 2'h0;
    if (route_ok_reg)
      rx = rx_sync[in_port_reg];
    else
      rx = |rx_sync;
    tok_next  = {rx, tok_reg[3:1]};
    tok_done  = st_reg[1] && bit_reg == 6'h03;
    route_tok = tok_done && tok_next[3:2] == `TOK_ROUTE_HI;
  end

  // ---------------------------------------------------------------
  // value captured for the selected data register
  // ---------------------------------------------------------------
  always @* begin
    case (ir_reg)
      `DR_PRESET:  cap_val = {16'h0000, preset_reg};
      `DR_RESET:   cap_val = {31'h0, node_reset};
      `DR_ERR:     cap_val = {25'h0, err_reg};
      `DR_BOOT:    cap_val = {30'h0, cpu_release, boot_lvl_reg};
      `DR_NODE:    cap_val = {net_size_reg, node_addr_reg};
      `DR_IC_ADDR: cap_val = {20'h0, ic_addr};
      default:     cap_val = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // packet receive, forward and shift
  // ---------------------------------------------------------------
  // every packet is delayed eight cycles through the node so that a
  // route token can be swallowed before its start bit leaves
  always @(posedge core_clk) begin
    if (reset) begin
      st_reg    <= ST_IDLE;
      bit_reg   <= 6'h00;
      tok_reg   <= 4'h0;
      sh_dr_reg <= 1'b0;
      line_reg  <= 5'h00;
      ser_out   <= 4'h0;
      ir_sr_reg <= 32'h0000_0000;
      dr_sr_reg <= 32'h0000_0000;
      ir_reg    <= 3'h0;
    end else begin
      ser_out               <= 4'h0;
      ser_out[out_port_reg] <= line_reg[4];
      line_reg              <= {line_reg[3:0], rx};
      case (st_reg)
        ST_IDLE: begin
          bit_reg <= 6'h00;
          if (rx)
            st_reg <= ST_TOK;
        end
        ST_TOK: begin
          tok_reg <= tok_next;
          bit_reg <= bit_reg + 6'h01;
          if (tok_done) begin
            bit_reg <= 6'h00;
            st_reg  <= ST_IDLE;
            if (route_tok)
              line_reg <= 5'h00;
            else if (tok_next == `TOK_SH_IR ||
                     tok_next == `TOK_SH_DR) begin
              st_reg    <= ST_DATA;
              sh_dr_reg <= tok_next == `TOK_SH_DR;
            end
            if (tok_next == `TOK_CAP_IR)
              ir_sr_reg <= {29'h0, ir_reg};
            if (tok_next == `TOK_UPD_IR)
              ir_reg <= ir_sr_reg[2:0];
          end
        end
        ST_DATA: begin
          // shift register sits in the chain: old bit out, new in
          bit_reg <= bit_reg + 6'h01;
          if (sh_dr_reg) begin
            dr_sr_reg   <= {rx, dr_sr_reg[31:1]};
            line_reg[0] <= dr_sr_reg[0];
          end else begin
            ir_sr_reg   <= {rx, ir_sr_reg[31:1]};
            line_reg[0] <= ir_sr_reg[0];
          end
          if (bit_reg == 6'h1F)
            st_reg <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
      if (cd_fire)
        dr_sr_reg <= cap_val;
    end
  end

  // ---------------------------------------------------------------
  // route, preset and node identity
  // ---------------------------------------------------------------
  // a route token arrives on the upstream port and names the port
  // leaving; software may rewrite both after a link fault
  always @(posedge core_clk) begin
    if (reset) begin
      in_port_reg   <= `RST_PORT;
      out_port_reg  <= `RST_PORT;
      route_ok_reg  <= 1'b0;
      preset_reg    <= `RST_PRESET;
      node_addr_reg <= 16'h0000;
      net_size_reg  <= 16'h0000;
    end else begin
      if (route_tok) begin
        out_port_reg <= tok_next[1:0];
        route_ok_reg <= 1'b1;
        if (!route_ok_reg)
          in_port_reg <= first_port;
      end
      if (apb_wr && paddr == `OFS_CTRL) begin
        in_port_reg  <= pwdata[`CTRL_IN_LSB +: 2];
        out_port_reg <= pwdata[`CTRL_OUT_LSB +: 2];
        route_ok_reg <= pwdata[`CTRL_VALID];
      end
      if (apb_wr && paddr == `OFS_PRESET)
        preset_reg <= pwdata[15:0];
      if (tok_done && tok_next == `TOK_UPD_DR) begin
        if (ir_reg == `DR_PRESET)
          preset_reg <= dr_sr_reg[15:0];
        if (ir_reg == `DR_NODE) begin
          node_addr_reg <= dr_sr_reg[15:0];
          net_size_reg  <= dr_sr_reg[31:16];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // node reset, bootstrap and icache load
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      node_reset   <= 1'b0;
      boot_lvl_reg <= 1'b0;
      cache_lock   <= 1'b1;
      cpu_release  <= 1'b0;
      ic_we        <= 1'b0;
      ic_addr      <= 12'h000;
      ic_wdata     <= 32'h0000_0000;
    end else begin
      ic_we      <= 1'b0;
      cache_lock <= ~boot_lvl_reg;
      if (ic_we)
        ic_addr <= ic_addr + 12'h001;
      if (tok_done && tok_next == `TOK_UPD_DR) begin
        case (ir_reg)
          `DR_RESET: node_reset <= dr_sr_reg[0];
          `DR_BOOT: begin
            cpu_release  <= dr_sr_reg[1];
            boot_lvl_reg <= dr_sr_reg[0];
          end
          `DR_IC_DATA: begin
            ic_we    <= 1'b1;
            ic_wdata <= dr_sr_reg;
          end
          `DR_IC_ADDR: ic_addr <= dr_sr_reg[11:0];
          default: ic_we <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // sticky error flags
  // ---------------------------------------------------------------
  // an event in the clearing cycle keeps its flag set
  always @(posedge core_clk) begin
    if (reset) begin
      err_reg <= 7'h00;
    end else begin
      if (tok_done && tok_next == `TOK_UPD_DR && ir_reg == `DR_ERR)
        err_reg <= (err_reg & ~dr_sr_reg[6:0]) | err_evt;
      else if (apb_wr && paddr == `OFS_ERR)
        err_reg <= (err_reg & ~pwdata[6:0]) | err_evt;
      else
        err_reg <= err_reg | err_evt;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      int_stat_reg <= 3'h0;
      int_mask_reg <= 3'h0;
      irq          <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_reg
        & ~((apb_wr && paddr == `OFS_INT_STAT) ? pwdata[2:0] : 3'h0)
        | {|err_evt, cd_fire, tok_done};
      if (apb_wr && paddr == `OFS_INT_MASK)
        int_mask_reg <= pwdata[2:0];
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // apb read decode
  // ---------------------------------------------------------------
  always @* begin
    map_hit = 1'b1;
    case (paddr)
      `OFS_CTRL:     rd_mux = {27'h0, route_ok_reg, out_port_reg,
                               in_port_reg};
      `OFS_STATUS:   rd_mux = {24'h0, ir_reg, cd_busy, cpu_release,
                               boot_lvl_reg, node_reset, st_reg[0]};
      `OFS_INT_STAT: rd_mux = {29'h0, int_stat_reg};
      `OFS_INT_MASK: rd_mux = {29'h0, int_mask_reg};
      `OFS_PRESET:   rd_mux = {16'h0000, preset_reg};
      `OFS_ERR:      rd_mux = {25'h0, err_reg};
      `OFS_NODE:     rd_mux = {net_size_reg, node_addr_reg};
      default: begin
        rd_mux  = 32'h0000_0000;
        map_hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // apb handshake: ready in the first access cycle
  // ---------------------------------------------------------------
  // registered ready costs no wait state and keeps outputs on flops
  always @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~map_hit;
      if (apb_setup && !pwrite)
        prdata <= rd_mux;
    end
  end
endmodule

//--- tb/serial_diag_port_props.sv
// concurrent checks on the serial diagnostic port pins
module serial_diag_port_props (
  input logic        core_clk,    // system clock
  input logic        reset,       // synchronous, active high
  input logic        psel,        // apb select
  input logic        penable,     // apb access phase
  input logic        pwrite,      // apb direction
  input logic [31:0] prdata,      // apb read data
  input logic        pready,      // apb ready
  input logic        pslverr,     // apb error
  input logic [3:0]  ser_in,      // serial inputs
  input logic [3:0]  ser_out,     // serial outputs
  input logic        node_reset,  // selective node reset
  input logic        cache_lock,  // caches act as memory
  input logic        cpu_release, // processor released
  input logic        ic_we,       // icache write strobe
  input logic        irq          // level interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // -------------------------------------------------------------
  // helper: cycles since serial input was nonzero
  // -------------------------------------------------------------
  logic [5:0] idle_cnt; // saturates, a packet drains in 45
  always @(posedge core_clk) begin
    if (reset || ser_in != 4'h0)
      idle_cnt <= 6'h00;
    else if (idle_cnt != 6'h3F)
      idle_cnt <= idle_cnt + 6'h01;
  end
  // -------------------------------------------------------------
  // bus handshake steps
  // -------------------------------------------------------------
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  a_setup_then_ready: assert property (setup_s |=> access_s)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_needs_setup: assert property
    ($rose(pready) |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_zero: assert property
    (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_reset_state: assert property (disable iff (1'b0)
    reset |=> ser_out == 4'h0 && cache_lock && !cpu_release
              && !node_reset && !ic_we && !irq)
    else $error("bad state after reset");
  a_one_out_port: assert property ($onehot0(ser_out))
    else $error("two ports driven");
  a_idle_quiet: assert property
    (idle_cnt >= 6'h30 |-> ser_out == 4'h0)
    else $error("output without input packet");
  a_we_pulse: assert property (ic_we |=> !ic_we)
    else $error("icache strobe too long");
endmodule

bind serial_diag_port serial_diag_port_props props_inst (.core_clk, .reset,
  .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .ser_in, .ser_out,
  .node_reset, .cache_lock, .cpu_release, .ic_we, .irq);

//--- tb/diag_neighbour.sv
// neighbouring node model that sends and receives packets
`include "diag_port_defs.vh"
module diag_neighbour (
  input  logic core_clk, // shared system clock
  input  logic reset,    // synchronous, active high
  output logic line_out, // serial line into the port
  input  logic line_in   // serial line from the port
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] rx_sr;  // arriving bits, lsb first
  logic [5:0]  rx_n;   // bit position, 0 while idle
  logic [3:0]  rx_tok; // last token received
  logic [31:0] rx_dat; // last data word received
  int          rx_cnt; // packets received
  wire  [35:0] rx_nx = {line_in, rx_sr[35:1]};
  initial line_out = 1'b0; // idle low, no pull-up on the line
  // start bit, token, data for shifts, lsb first, then idle
  task automatic send(input logic [3:0] tok, input logic [31:0] dat);
    logic [36:0] bits;
    int          n;
    bits = {dat, tok, 1'b1};
    n = (tok == `TOK_SH_IR || tok == `TOK_SH_DR) ? 37 : 5;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      line_out <= bits[i];
    end
    @(posedge core_clk);
    line_out <= 1'b0; // gap keeps packets apart
  endtask
  // -------------------------------------------------------------
  // receiver: token decides if 32 data bits follow
  // -------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      rx_n   <= 6'h00;
      rx_cnt <= 0;
    end else if (rx_n == 6'h00) begin
      if (line_in)
        rx_n <= 6'h01; // start bit seen
    end else begin
      rx_sr <= rx_nx;
      rx_n  <= rx_n + 6'h01;
      if (rx_n == 6'h24 || (rx_n == 6'h04 && rx_nx[35:32] != `TOK_SH_IR
          && rx_nx[35:32] != `TOK_SH_DR)) begin
        rx_tok <= rx_n == 6'h24 ? rx_nx[3:0] : rx_nx[35:32];
        rx_dat <= rx_nx[35:4];
        rx_n   <= 6'h00;
        rx_cnt <= rx_cnt + 1;
      end
    end
  end
endmodule

//--- tb/tb_serial_diag_port.sv
// self-checking bench for the serial diagnostic port
`include "diag_port_defs.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end
module tb_serial_diag_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        err, mem_err = 0;
  logic [3:0]  link_err = 4'h0;
  wire  [31:0] prdata, ic_wdata;
  wire  [11:0] ic_addr;
  wire  [3:0]  ser_out;
  wire         pready, pslverr, node_reset, cache_lock, cpu_release;
  wire         ic_we, irq, up_line;
  logic [11:0] we_addr;
  logic [31:0] we_data;
  int          bad_count = 0, checks = 0, we_cnt = 0, n0, n1, c;
  always #5 core_clk = ~core_clk;
  serial_diag_port serial_diag_port_inst (.core_clk, .reset, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ser_in({3'h0, up_line}), .ser_out, .mem_par_err(mem_err),
    .msg_par_err(1'b0), .addr_rng_err(1'b0), .link_err, .node_reset,
    .cache_lock, .cpu_release, .ic_we, .ic_addr, .ic_wdata, .irq);
  // upstream neighbour on north, downstream seen on south
  diag_neighbour diag_neighbour_inst (.core_clk, .reset, .line_out(up_line),
    .line_in(ser_out[2]));
  // log icache writes to check address stepping
  always @(posedge core_clk) begin
    if (ic_we === 1'b1) begin
      we_cnt  <= we_cnt + 1;
      we_addr <= ic_addr;
      we_data <= ic_wdata;
    end
  end
  // one apb transfer, held until ready
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int n = 0;
    tick(1);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      bad_count++; // no answer
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic tx(input logic [3:0] t, input logic [31:0] v);
    diag_neighbour_inst.send(t, v);
  endtask
  task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK(rd, e)
  endtask
  // shift packet, forwarded copy carries old contents
  task automatic shift_out(input logic [3:0] t, input logic [31:0] v,
                           input logic [31:0] e);
    int n = 0;
    c = diag_neighbour_inst.rx_cnt;
    tx(t, v);
    while (diag_neighbour_inst.rx_cnt == c && n < 60) begin
      tick(1);
      n++;
    end
    `CHK({diag_neighbour_inst.rx_tok, diag_neighbour_inst.rx_dat}, {t, e})
  endtask
  task automatic ir_set(input logic [31:0] v);
    tx(`TOK_SH_IR, v);
    tx(`TOK_UPD_IR, 32'h0);
  endtask
  task automatic dr_wr(input logic [31:0] v);
    tx(`TOK_SH_DR, v);
    tx(`TOK_UPD_DR, 32'h0);
    tick(16); // let the update land
  endtask
  // cycles from capture token to interrupt
  task automatic cap_time(input logic [15:0] p, output int n);
    apb(`OFS_PRESET, 1'b1, {16'h0000, p});
    apb(`OFS_INT_STAT, 1'b1, 32'h7);
    tx(`TOK_CAP_DR, 32'h0);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog, tests need under 10000 cycles
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
  // -------------------------------------------------------------
  // test sequence
  // -------------------------------------------------------------
  initial begin
    tick(3);
    reset <= 1'b0;
    chk_rd(`OFS_CTRL, 32'h0000_0000);
    chk_rd(`OFS_PRESET, 32'h0000_0000);
    `CHK(cache_lock, 1'b1)
    apb(12'h01C, 1'b0, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    $display("test reset and bus done");
    c = diag_neighbour_inst.rx_cnt;
    tx({`TOK_ROUTE_HI, 2'h2}, 32'h0);
    tick(20);
    `CHK(diag_neighbour_inst.rx_cnt, c)
    chk_rd(`OFS_CTRL, 32'h0000_0018);
    chk_rd(`OFS_INT_STAT, 32'h0000_0001);
    `CHK(irq, 1'b0)
    shift_out(`TOK_SH_IR, 32'hA5C3_0F12, 32'h0);
    shift_out(`TOK_SH_IR, 32'h1, 32'hA5C3_0F12);
    tx(`TOK_UPD_IR, 32'h0);
    tick(16);
    apb(`OFS_STATUS, 1'b0, 32'h0);
    `CHK(rd[7:5], 3'h1)
    $display("test route and shift done");
    apb(`OFS_INT_MASK, 1'b1, 32'h2);
    cap_time(16'h0000, n0);
    cap_time(16'h0007, n1);
    `CHK(n1 - n0, 7)
    `CHK(n0 < 20, 1'b1)
    $display("test countdown done");
    apb(`OFS_INT_MASK, 1'b1, 32'h4);
    apb(`OFS_INT_STAT, 1'b1, 32'h7);
    mem_err <= 1'b1;
    link_err <= 4'h8;
    tick(1);
    mem_err <= 1'b0;
    link_err <= 4'h0;
    tick(3);
    `CHK(irq, 1'b1)
    chk_rd(`OFS_ERR, 32'h0000_0041);
    ir_set({29'h0, `DR_ERR});
    tx(`TOK_CAP_DR, 32'h0);
    tick(20);
    shift_out(`TOK_SH_DR, 32'h0, 32'h0000_0041);
    apb(`OFS_ERR, 1'b1, 32'h7F);
    apb(`OFS_INT_STAT, 1'b1, 32'h7);
    chk_rd(`OFS_ERR, 32'h0000_0000);
    `CHK(irq, 1'b0)
    $display("test error flags done");
    ir_set({29'h0, `DR_BOOT});
    dr_wr(32'h2);
    `CHK({cpu_release, cache_lock}, 2'h3)
    dr_wr(32'h1);
    `CHK({cpu_release, cache_lock}, 2'h0)
    ir_set({29'h0, `DR_IC_ADDR});
    dr_wr(32'h0000_00AB);
    ir_set({29'h0, `DR_IC_DATA});
    dr_wr(32'h1234_5678);
    dr_wr(32'h9ABC_DEF0);
    `CHK(we_cnt, 2)
    `CHK({we_addr, we_data}, {12'h0AC, 32'h9ABC_DEF0})
    ir_set({29'h0, `DR_RESET});
    dr_wr(32'h1);
    `CHK(node_reset, 1'b1)
    dr_wr(32'h0);
    `CHK(node_reset, 1'b0)
    $display("test boot and node reset done");
    tick(60);
    end_sim();
  end
endmodule
